/* File: dv/ieb_chk.sv */
// Purpose: port checker for the interrupt flag and enable bank
// Assumes: apb master holds a request until ready
// Notes:   bound into ieb_top at the foot of this file
`timescale 1ns/10ps
`default_nettype none
module ieb_chk #(
    parameter int ADDR_W = 8 // apb address width
) (
    input wire logic              CLK,          // clock
    input wire logic              SRST,         // reset
    input wire logic              PSEL,         // select
    input wire logic              PENABLE,      // enable
    input wire logic              PWRITE,       // direction
    input wire logic [ADDR_W-1:0] PADDR,        // address
    input wire logic [31:0]       PWDATA,       // write data
    input wire logic [31:0]       PRDATA,       // read data
    input wire logic              PREADY,       // ready
    input wire logic              SVC_ACK,      // service
    input wire logic              CORE_IRQ_REQ, // core request
    input wire logic              IRQ           // status irq
);
    logic done;
    logic rdy;
    logic wrd;
    // finished transfers; the bus moves flags or enables only through these
    assign done = PSEL && PENABLE && PREADY;
    assign rdy  = done && !PWRITE;
    assign wrd  = done && PWRITE;
    default clocking @(posedge CLK); endclocking
    default disable iff (SRST);
    // one wait state, never a held ready
    property p_rdy;
        PSEL && PENABLE && !PREADY |=> PREADY ##1 !PREADY;
    endproperty
    a_rdy: assert property (p_rdy) else $error("ready timing");
    // unused bits of partly filled words read zero
    property p_edge;
        rdy && PADDR == ieb_pkg::OFS_EDGE |-> PRDATA[31:4] == 28'h0;
    endproperty
    a_edge: assert property (p_edge) else $error("edge bits");
    property p_c0;
        rdy && PADDR == ieb_pkg::OFS_CTRL0 |-> PRDATA[31:7] == 25'h0;
    endproperty
    a_c0: assert property (p_c0) else $error("ctrl0 bit 7");
    property p_full;
        rdy && (PADDR == ieb_pkg::OFS_CTRL1 || PADDR == ieb_pkg::OFS_CTRL2
                || PADDR == ieb_pkg::OFS_GRP1)
            |-> PRDATA[31:8] == 24'h0;
    endproperty
    a_full: assert property (p_full) else $error("wide");
    property p_grp;
        rdy && (PADDR == ieb_pkg::OFS_GRP0 || PADDR == ieb_pkg::OFS_GRP2)
            |-> (PRDATA & ~{24'h0, ieb_pkg::IMPL_GRPH}) == 32'h0;
    endproperty
    a_grp: assert property (p_grp) else $error("group bits");
    // global enable off or a service drops the request two edges on
    property p_gie;
        wrd && PADDR == ieb_pkg::OFS_CTRL0 && !PWDATA[0] |-> ##2 !CORE_IRQ_REQ;
    endproperty
    a_gie: assert property (p_gie) else $error("gie off");
    property p_svc;
        SVC_ACK && !wrd |-> ##2 !CORE_IRQ_REQ;
    endproperty
    a_svc: assert property (p_svc) else $error("service");
    // a request or irq only falls after software or the core acted
    property p_fall;
        $fell(CORE_IRQ_REQ) |-> $past(SVC_ACK, 2) || $past(wrd, 2);
    endproperty
    a_fall: assert property (p_fall) else $error("req fell");
    property p_irq;
        $fell(IRQ) |-> $past(done);
    endproperty
    a_irq: assert property (p_irq) else $error("irq fell");
    c_svc: cover property (SVC_ACK);
    c_irq: cover property ($rose(IRQ));
    c_req: cover property ($rose(CORE_IRQ_REQ));
endmodule : ieb_chk
bind ieb_top ieb_chk #(.ADDR_W(ADDR_W)) u_chk (.CLK(CLK), .SRST(SRST),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .SVC_ACK(SVC_ACK),
    .CORE_IRQ_REQ(CORE_IRQ_REQ), .IRQ(IRQ));
`default_nettype wire

/* File: dv/ieb_far.sv */
// Purpose: far side model: peripherals, pins and core
// Assumes: bench commands change right after CLK rises
// Notes:   core takes a request once, then holds off for two edges before it can take another
`timescale 1ns/10ps
`default_nettype none
module ieb_far (
    input  wire logic        clk,     // system clock
    input  wire logic [13:0] fire,    // event commands
    input  wire logic [1:0]  pins,    // pin levels
    input  wire logic        ack_en,  // core takes requests
    input  wire logic [3:0]  ack_src, // source to service
    input  wire logic        req,     // request from bank
    output logic      [13:0] evt,     // peripheral pulses
    output logic      [1:0]  pin_out, // pin wires
    output logic             ack,     // service pulse
    output logic      [3:0]  src      // serviced source
);
    logic ack_r = 1'h0;
    logic ack_d = 1'h0;
    // holdoff of two: the request drops two edges after service
    always @(posedge clk) begin
        ack_r <= ack_en && req && !ack_r && !ack_d;
        ack_d <= ack_r;
    end
    // events and pins follow the bench commands directly
    assign ack     = ack_r;
    assign src     = ack_src;
    assign evt     = fire;
    assign pin_out = pins;
endmodule : ieb_far
`default_nettype wire

/* File: dv/test_mcu_interrupt_flag_enable_bank.sv */
// Purpose: self-checking bench for the interrupt flag and enable bank
// Assumes: apb with one wait state; far side model services requests
// Notes:   expected words come from the register map bit positions
`timescale 1ns/10ps
`default_nettype none
module test_mcu_interrupt_flag_enable_bank;
    logic        clk = 1'h0;
    logic        srst = 1'h1;
    logic        psel = 1'h0;
    logic        pen = 1'h0;
    logic        pwr = 1'h0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready, pslverr, req, irq, ack, err;
    logic        ack_en = 1'h0;
    logic [3:0]  src;
    logic [3:0]  ack_src = 4'h0;
    logic [13:0] fire = 14'h0;
    logic [13:0] evt;
    logic [1:0]  pins = 2'h0;
    logic [1:0]  pin_o;
    logic [31:0] rd;
    int          error_cnt = 0;
    int          samples_checked = 0;
    // offset, flag word, group offset, group word for each event
    localparam logic [31:0] EV_TAB [14] = '{32'h04200000, 32'h08400000,
        32'h08800000, 32'h0C100000, 32'h0C400000, 32'h0C800000,
        32'h10200440, 32'h10100440, 32'h14800810, 32'h14400810,
        32'h14200810, 32'h14100810, 32'h18100820, 32'h18200820};
    localparam logic [31:0] BANK_MASK [7] = '{32'h0F, 32'h7F, 32'hFF,
        32'hFF, 32'h33, 32'hFF, 32'h33};
    initial forever #50 clk = ~clk;
    ieb_top u_dut (.CLK(clk), .SRST(srst), .PSEL(psel), .PENABLE(pen),
        .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .EXT_PIN_ZERO(pin_o[0]),
        .EXT_PIN_ONE(pin_o[1]), .EVT_COMPARATOR(evt[0]), .EVT_ADC(evt[1]),
        .EVT_TIMEBASE0(evt[2]), .EVT_TIMEBASE1(evt[3]),
        .EVT_SERIAL_IF(evt[4]), .EVT_UART(evt[5]), .EVT_STD_CMPA(evt[6]),
        .EVT_STD_CMPP(evt[7]), .EVT_COMPACT_CMPA(evt[8]),
        .EVT_COMPACT_CMPP(evt[9]), .EVT_PERIODIC_CMPA(evt[10]),
        .EVT_PERIODIC_CMPP(evt[11]), .EVT_LOWVOLT(evt[12]),
        .EVT_NVM_WRITE(evt[13]), .SVC_ACK(ack), .SVC_SRC(src),
        .CORE_IRQ_REQ(req), .IRQ(irq));
    ieb_far u_far (.clk(clk), .fire(fire), .pins(pins), .ack_en(ack_en),
        .ack_src(ack_src), .req(req), .evt(evt), .pin_out(pin_o),
        .ack(ack), .src(src));
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : report_and_stop
    task automatic check(input string what, input logic [31:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s exp %h seen %h", what, exp, seen);
        end
    endtask : check
    // request held until ready is seen at an edge; one idle cycle after
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        psel   <= 1'h1;
        pwr    <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'h1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'h1 && n < 20);
        rd  = prdata;
        err = pslverr;
        psel <= 1'h0;
        pen  <= 1'h0;
        if (n == 20) begin
            error_cnt++;
            report_and_stop();
        end
        @(posedge clk);
    endtask : apb
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'h0, a, 32'h0);
        check($sformatf("reg %h", a), rd, exp);
    endtask : rd_chk
    task automatic wait_lvl(input logic exp);
        int n;
        n = 0;
        while (req !== exp && n < 10) begin
            @(posedge clk);
            n++;
        end
        check("core request", {31'h0, req}, {31'h0, exp});
        if (req !== exp)
            report_and_stop();
    endtask : wait_lvl
    // zero the bank, then a status read so no stale bit survives
    task automatic clr;
        for (int i = 0; i < 7; i++)
            apb(1'h1, 8'(4 * i), 32'h0);
        apb(1'h0, ieb_pkg::OFS_STATUS, 32'h0);
    endtask : clr
    task automatic pulse(input logic [13:0] v);
        fire <= v;
        @(posedge clk);
        fire <= 14'h0;
        @(posedge clk);
    endtask : pulse
    initial begin
        logic [7:0]  ro;
        logic [31:0] t;
        repeat (10) @(posedge clk);
        srst <= 1'h0;
        @(posedge clk);
        // every word resets to zero; one past the map is refused
        for (int i = 0; i < 9; i++)
            rd_chk(8'(4 * i), 32'h0);
        apb(1'h0, 8'h24, 32'h0);
        check("unmapped err", {31'h0, err}, 32'h1);
        $display("test reset done");
        // all ones, group words first so group flags also rise
        for (int i = 6; i >= 0; i--)
            apb(1'h1, 8'(4 * i), 32'hFFFFFFFF);
        for (int i = 0; i < 7; i++)
            rd_chk(8'(4 * i), BANK_MASK[i]);
        wait_lvl(1'h1);
        rd_chk(ieb_pkg::OFS_STATUS, 32'h7FF);
        rd_chk(ieb_pkg::OFS_STATUS, 32'h0);
        apb(1'h1, ieb_pkg::OFS_CTRL0, 32'h7E);
        wait_lvl(1'h0);
        clr();
        $display("test access done");
        // each event alone sets its flag, enables untouched
        for (int i = 0; i < 14; i++) begin
            t = EV_TAB[i];
            pulse(14'(1 << i));
            rd_chk(t[31:24], {24'h0, t[23:16]});
            if (t[15:8] != 8'h0)
                rd_chk(t[15:8], {24'h0, t[7:0]});
            clr();
        end
        $display("test events done");
        // every edge code on each pin, rising then falling level
        for (int p = 0; p < 2; p++)
            for (int c = 0; c < 4; c++) begin
                ro = p ? ieb_pkg::OFS_CTRL2 : ieb_pkg::OFS_CTRL0;
                t = p ? 32'h20 : 32'h10;
                apb(1'h1, ieb_pkg::OFS_EDGE, 32'(c << (2 * p)));
                pins[p] <= 1'h1;
                repeat (5) @(posedge clk);
                rd_chk(ro, c[0] ? t : 32'h0);
                apb(1'h1, ro, 32'h0);
                pins[p] <= 1'h0;
                repeat (5) @(posedge clk);
                rd_chk(ro, c[1] ? t : 32'h0);
                clr();
            end
        $display("test pins done");
        // group 0 member raised; core services group 0
        apb(1'h1, ieb_pkg::OFS_CTRL0, 32'h09);
        ack_src <= 4'h2;
        ack_en  <= 1'h1;
        pulse(14'h0040);
        wait_lvl(1'h1);
        wait_lvl(1'h0);
        ack_en <= 1'h0;
        rd_chk(ieb_pkg::OFS_CTRL0, 32'h08);
        rd_chk(ieb_pkg::OFS_GRP0, 32'h20);
        clr();
        $display("test service done");
        // comparator unmasked only, so the adc event stays quiet
        apb(1'h1, ieb_pkg::OFS_MASK, 32'h2);
        rd_chk(ieb_pkg::OFS_MASK, 32'h2);
        pulse(14'h0002);
        check("irq masked", {31'h0, irq}, 32'h0);
        pulse(14'h0001);
        check("irq", {31'h0, irq}, 32'h1);
        rd_chk(ieb_pkg::OFS_STATUS, 32'h22);
        check("irq cleared", {31'h0, irq}, 32'h0);
        $display("test irq done");
        report_and_stop();
    end
endmodule : test_mcu_interrupt_flag_enable_bank
`default_nettype wire

/* File: src/ieb_pkg.sv */
// Purpose: shared constants for the interrupt flag and enable bank
// Assumes: APB slave with 32-bit data, 8-bit bank registers in low byte lanes, 11-bit status and mask
// Notes:   byte offsets, bit masks and source indices live only here
package ieb_pkg;

    // register bank indices
    localparam int BANK_N    = 7;
    localparam int IDX_EDGE  = 0;
    localparam int IDX_CTRL0 = 1;
    localparam int IDX_CTRL1 = 2;
    localparam int IDX_CTRL2 = 3;
    localparam int IDX_GRP0  = 4;
    localparam int IDX_GRP1  = 5;
    localparam int IDX_GRP2  = 6;

    // byte offsets on the bus
    localparam logic [7:0] OFS_EDGE   = 8'h00;
    localparam logic [7:0] OFS_CTRL0  = 8'h04;
    localparam logic [7:0] OFS_CTRL1  = 8'h08;
    localparam logic [7:0] OFS_CTRL2  = 8'h0C;
    localparam logic [7:0] OFS_GRP0   = 8'h10;
    localparam logic [7:0] OFS_GRP1   = 8'h14;
    localparam logic [7:0] OFS_GRP2   = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1C;
    localparam logic [7:0] OFS_MASK   = 8'h20;

    // implemented bits and flag bits per bank register
    localparam logic [7:0] IMPL_EDGE = 8'h0F;
    localparam logic [7:0] IMPL_C0   = 8'h7F;
    localparam logic [7:0] IMPL_FULL = 8'hFF;
    localparam logic [7:0] IMPL_GRPH = 8'h33;
    localparam logic [7:0] FLG_C0    = 8'h70;
    localparam logic [7:0] FLG_HI    = 8'hF0;
    localparam logic [7:0] FLG_GRPH  = 8'h30;
    localparam logic [7:0] RST_BYTE  = 8'h00;

    // bit positions
    localparam int GIE_BIT    = 0;
    localparam int GRP0_BIT   = 6;
    localparam int CMP_BIT    = 5;
    localparam int PIN0_BIT   = 4;
    localparam int TB0_BIT    = 7;
    localparam int ADC_BIT    = 6;
    localparam int GRP2_BIT   = 5;
    localparam int GRP1_BIT   = 4;
    localparam int UART_BIT   = 7;
    localparam int SER_BIT    = 6;
    localparam int PIN1_BIT   = 5;
    localparam int TB1_BIT    = 4;
    localparam int MFA_HI_BIT = 7;
    localparam int MFB_HI_BIT = 6;
    localparam int MFA_LO_BIT = 5;
    localparam int MFB_LO_BIT = 4;
    localparam int PIN1_SEL_LSB = 2;
    localparam int PIN0_SEL_LSB = 0;

    // edge select codes
    localparam logic [1:0] EDGE_OFF  = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;

    // primary source count; index order is the packed flag order
    localparam int SRC_N = 11;

endpackage : ieb_pkg

/* File: src/ieb_top.sv */
// Purpose: interrupt request flag and enable bank with APB access
// Assumes: event inputs are one-cycle pulses on CLK; pins are async
// Notes:   service acknowledge comes from the core on CLK
//
// Chosen here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none

module ieb_top #(
    parameter int ADDR_W = 8                     // apb address width
) (
    input  wire logic              CLK,            // system clock
    input  wire logic              SRST,           // sync reset, high
    input  wire logic              PSEL,           // apb select
    input  wire logic              PENABLE,        // apb enable
    input  wire logic              PWRITE,         // apb direction
    input  wire logic [ADDR_W-1:0] PADDR,          // apb byte address
    input  wire logic [31:0]       PWDATA,         // apb write data
    output logic      [31:0]       PRDATA,         // apb read data
    output logic                   PREADY,         // apb ready
    output logic                   PSLVERR,        // unmapped access
    input  wire logic              EXT_PIN_ZERO,   // async pin 0
    input  wire logic              EXT_PIN_ONE,    // async pin 1
    input  wire logic              EVT_COMPARATOR, // comparator toggle
    input  wire logic              EVT_ADC,        // conversion done
    input  wire logic              EVT_TIMEBASE0,  // time base 0 tick
    input  wire logic              EVT_TIMEBASE1,  // time base 1 tick
    input  wire logic              EVT_SERIAL_IF,  // serial if event
    input  wire logic              EVT_UART,       // uart event
    input  wire logic              EVT_STD_CMPA,   // std timer cmp a
    input  wire logic              EVT_STD_CMPP,   // std timer cmp p
    input  wire logic              EVT_COMPACT_CMPA, // compact cmp a
    input  wire logic              EVT_COMPACT_CMPP, // compact cmp p
    input  wire logic              EVT_PERIODIC_CMPA, // periodic cmp a
    input  wire logic              EVT_PERIODIC_CMPP, // periodic cmp p
    input  wire logic              EVT_LOWVOLT,    // low voltage seen
    input  wire logic              EVT_NVM_WRITE,  // nvm write done
    input  wire logic              SVC_ACK,        // core takes a source
    input  wire logic [3:0]        SVC_SRC,        // index of that source
    output logic                   CORE_IRQ_REQ,   // request to core
    output logic                   IRQ             // status irq level
);

    // decoders look at address bits 7..0, so narrower buses cannot work
    if (ADDR_W < 8) begin : g_addr_chk
        $error("ADDR_W too small for register map");
    end

    // pack primary flags: {ctrl2[7:4], ctrl1[7:4], ctrl0[6:4]}
    function automatic logic [10:0] pack_flags(
        input logic [7:0] c0,
        input logic [7:0] c1,
        input logic [7:0] c2
    );
        pack_flags = {c2[7:4], c1[7:4], c0[6:4]};
    endfunction : pack_flags

    // pack matching enables in the same order
    function automatic logic [10:0] pack_enables(
        input logic [7:0] c0,
        input logic [7:0] c1,
        input logic [7:0] c2
    );
        pack_enables = {c2[3:0], c1[3:0], c0[3:1]};
    endfunction : pack_enables

    // edge match for one pin field
    function automatic logic edge_hit(
        input logic [1:0] sel,
        input logic       rise,
        input logic       fall
    );
        case (sel)
            ieb_pkg::EDGE_RISE: edge_hit = rise;
            ieb_pkg::EDGE_FALL: edge_hit = fall;
            ieb_pkg::EDGE_BOTH: edge_hit = rise | fall;
            default:            edge_hit = 1'h0;
        endcase
    endfunction : edge_hit

    // writable bits of each bank register
    function automatic logic [7:0] impl_mask(input int idx);
        case (idx)
            ieb_pkg::IDX_EDGE:  impl_mask = ieb_pkg::IMPL_EDGE;
            ieb_pkg::IDX_CTRL0: impl_mask = ieb_pkg::IMPL_C0;
            ieb_pkg::IDX_GRP0:  impl_mask = ieb_pkg::IMPL_GRPH;
            ieb_pkg::IDX_GRP2:  impl_mask = ieb_pkg::IMPL_GRPH;
            default:            impl_mask = ieb_pkg::IMPL_FULL;
        endcase
    endfunction : impl_mask

    // bus offset to bank index, -1 when not a bank register
    function automatic int bank_index(input logic [ADDR_W-1:0] a);
        case (a[7:0])
            ieb_pkg::OFS_EDGE:  bank_index = ieb_pkg::IDX_EDGE;
            ieb_pkg::OFS_CTRL0: bank_index = ieb_pkg::IDX_CTRL0;
            ieb_pkg::OFS_CTRL1: bank_index = ieb_pkg::IDX_CTRL1;
            ieb_pkg::OFS_CTRL2: bank_index = ieb_pkg::IDX_CTRL2;
            ieb_pkg::OFS_GRP0:  bank_index = ieb_pkg::IDX_GRP0;
            ieb_pkg::OFS_GRP1:  bank_index = ieb_pkg::IDX_GRP1;
            ieb_pkg::OFS_GRP2:  bank_index = ieb_pkg::IDX_GRP2;
            default:            bank_index = -1;
        endcase
    endfunction : bank_index

    logic [7:0]  bank_r   [0:ieb_pkg::BANK_N-1];
    logic [7:0]  bank_nxt [0:ieb_pkg::BANK_N-1];
    logic [7:0]  set_v    [0:ieb_pkg::BANK_N-1];
    logic [7:0]  clr_v    [0:ieb_pkg::BANK_N-1];
    logic [10:0] status_r;
    logic [10:0] status_nxt;
    logic [10:0] mask_r;
    logic [10:0] svc_onehot;
    logic [10:0] prim_rise;
    logic [10:0] rd_snap_r;
    logic [2:0]  grp_rise;
    logic [1:0]  pin_meta_r;
    logic [1:0]  pin_sync_r;
    logic [1:0]  pin_prev_r;
    logic [1:0]  pin_rise;
    logic [1:0]  pin_fall;
    logic [31:0] rdata;
    logic        rd_err;
    logic        access;
    logic        done;
    logic        wr_done;
    logic        rd_done;
    logic        hi_upper;
    int          widx;

    // apb phases; the answer comes one cycle into the access phase
    assign access   = PSEL & PENABLE;
    assign done     = access & PREADY;
    assign wr_done  = done & PWRITE;
    assign rd_done  = done & ~PWRITE;
    assign widx     = bank_index(PADDR);
    assign hi_upper = (ADDR_W > 8) ? (PADDR >> 8) != '0 : 1'h0;

    // two-flop pin synchronisers; edges compare the second stage with its delayed copy
    always_ff @(posedge CLK) begin
        if (SRST) begin
            pin_meta_r <= 2'h0;
            pin_sync_r <= 2'h0;
            pin_prev_r <= 2'h0;
        end else begin
            pin_meta_r <= {EXT_PIN_ONE, EXT_PIN_ZERO};
            pin_sync_r <= pin_meta_r;
            pin_prev_r <= pin_sync_r;
        end
    end

    assign pin_rise = pin_sync_r & ~pin_prev_r;
    assign pin_fall = ~pin_sync_r & pin_prev_r;

    // service index to one-hot primary flag clear
    always_comb begin
        svc_onehot = 11'h000;
        if (SVC_ACK && (int'(SVC_SRC) < ieb_pkg::SRC_N)) begin
            svc_onehot[SVC_SRC] = 1'h1;
        end
    end

    // hardware set and service clear vectors per bank register
    always_comb begin
        for (int i = 0; i < ieb_pkg::BANK_N; i++) begin
            set_v[i] = 8'h00;
            clr_v[i] = 8'h00;
        end
        // pin edge fields drive the pin flags
        set_v[ieb_pkg::IDX_CTRL0][ieb_pkg::PIN0_BIT] = edge_hit(
            bank_r[ieb_pkg::IDX_EDGE][ieb_pkg::PIN0_SEL_LSB +: 2],
            pin_rise[0], pin_fall[0]);
        set_v[ieb_pkg::IDX_CTRL2][ieb_pkg::PIN1_BIT] = edge_hit(
            bank_r[ieb_pkg::IDX_EDGE][ieb_pkg::PIN1_SEL_LSB +: 2],
            pin_rise[1], pin_fall[1]);
        // internal sources straight into their flags
        set_v[ieb_pkg::IDX_CTRL0][ieb_pkg::CMP_BIT]  = EVT_COMPARATOR;
        set_v[ieb_pkg::IDX_CTRL1][ieb_pkg::TB0_BIT]  = EVT_TIMEBASE0;
        set_v[ieb_pkg::IDX_CTRL1][ieb_pkg::ADC_BIT]  = EVT_ADC;
        set_v[ieb_pkg::IDX_CTRL2][ieb_pkg::UART_BIT] = EVT_UART;
        set_v[ieb_pkg::IDX_CTRL2][ieb_pkg::SER_BIT]  = EVT_SERIAL_IF;
        set_v[ieb_pkg::IDX_CTRL2][ieb_pkg::TB1_BIT]  = EVT_TIMEBASE1;
        // group members
        set_v[ieb_pkg::IDX_GRP0][ieb_pkg::MFA_LO_BIT] = EVT_STD_CMPA;
        set_v[ieb_pkg::IDX_GRP0][ieb_pkg::MFB_LO_BIT] = EVT_STD_CMPP;
        set_v[ieb_pkg::IDX_GRP1][ieb_pkg::MFA_HI_BIT] = EVT_COMPACT_CMPA;
        set_v[ieb_pkg::IDX_GRP1][ieb_pkg::MFB_HI_BIT] = EVT_COMPACT_CMPP;
        set_v[ieb_pkg::IDX_GRP1][ieb_pkg::MFA_LO_BIT] = EVT_PERIODIC_CMPA;
        set_v[ieb_pkg::IDX_GRP1][ieb_pkg::MFB_LO_BIT] = EVT_PERIODIC_CMPP;
        set_v[ieb_pkg::IDX_GRP2][ieb_pkg::MFA_LO_BIT] = EVT_NVM_WRITE;
        set_v[ieb_pkg::IDX_GRP2][ieb_pkg::MFB_LO_BIT] = EVT_LOWVOLT;
        // service clears one primary flag and the global enable
        clr_v[ieb_pkg::IDX_CTRL0] = {1'h0, svc_onehot[2:0], 4'h0};
        clr_v[ieb_pkg::IDX_CTRL1] = {svc_onehot[6:3], 4'h0};
        clr_v[ieb_pkg::IDX_CTRL2] = {svc_onehot[10:7], 4'h0};
        clr_v[ieb_pkg::IDX_CTRL0][ieb_pkg::GIE_BIT] = SVC_ACK;
    end

    // next bank value; a hardware set always beats a clear or a write
    always_comb begin
        for (int i = 0; i < ieb_pkg::BANK_N; i++) begin
            if (wr_done && (widx == i) && !hi_upper) begin
                bank_nxt[i] = (PWDATA[7:0] & impl_mask(i))
                            | set_v[i];
            end else begin
                bank_nxt[i] = (bank_r[i] & ~clr_v[i]) | set_v[i];
            end
        end
        // group flags follow rising member flags, from any cause
        grp_rise[0] = |(bank_nxt[ieb_pkg::IDX_GRP0]
                      & ~bank_r[ieb_pkg::IDX_GRP0] & ieb_pkg::FLG_GRPH);
        grp_rise[1] = |(bank_nxt[ieb_pkg::IDX_GRP1]
                      & ~bank_r[ieb_pkg::IDX_GRP1] & ieb_pkg::FLG_HI);
        grp_rise[2] = |(bank_nxt[ieb_pkg::IDX_GRP2]
                      & ~bank_r[ieb_pkg::IDX_GRP2] & ieb_pkg::FLG_GRPH);
        bank_nxt[ieb_pkg::IDX_CTRL0][ieb_pkg::GRP0_BIT] =
            bank_nxt[ieb_pkg::IDX_CTRL0][ieb_pkg::GRP0_BIT]
            | grp_rise[0];
        bank_nxt[ieb_pkg::IDX_CTRL1][ieb_pkg::GRP1_BIT] =
            bank_nxt[ieb_pkg::IDX_CTRL1][ieb_pkg::GRP1_BIT]
            | grp_rise[1];
        bank_nxt[ieb_pkg::IDX_CTRL1][ieb_pkg::GRP2_BIT] =
            bank_nxt[ieb_pkg::IDX_CTRL1][ieb_pkg::GRP2_BIT]
            | grp_rise[2];
    end

    // bank storage; reset clears every implemented bit
    always_ff @(posedge CLK) begin
        if (SRST) begin
            for (int i = 0; i < ieb_pkg::BANK_N; i++) begin
                bank_r[i] <= ieb_pkg::RST_BYTE;
            end
        end else begin
            for (int i = 0; i < ieb_pkg::BANK_N; i++) begin
                bank_r[i] <= bank_nxt[i];
            end
        end
    end

    // sticky status: new primary flags; read clears only what was seen
    assign prim_rise = pack_flags(bank_nxt[ieb_pkg::IDX_CTRL0],
                                  bank_nxt[ieb_pkg::IDX_CTRL1],
                                  bank_nxt[ieb_pkg::IDX_CTRL2])
                     & ~pack_flags(bank_r[ieb_pkg::IDX_CTRL0],
                                   bank_r[ieb_pkg::IDX_CTRL1],
                                   bank_r[ieb_pkg::IDX_CTRL2]);

    always_comb begin
        status_nxt = status_r;
        if (rd_done && (PADDR[7:0] == ieb_pkg::OFS_STATUS) && !hi_upper) begin
            status_nxt = status_r & ~rd_snap_r;
        end
        status_nxt = status_nxt | prim_rise;
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            status_r <= 11'h000;
        end else begin
            status_r <= status_nxt;
        end
    end

    // status mask, software only
    always_ff @(posedge CLK) begin
        if (SRST) begin
            mask_r <= 11'h000;
        end else if (wr_done && (PADDR[7:0] == ieb_pkg::OFS_MASK)
                     && !hi_upper) begin
            mask_r <= PWDATA[10:0];
        end
    end

    // read mux; reserved and upper bits read zero
    always_comb begin
        rdata  = 32'h0000_0000;
        rd_err = 1'h0;
        if (hi_upper) begin
            rd_err = 1'h1;
        end else if (bank_index(PADDR) >= 0) begin
            rdata[7:0] = bank_r[bank_index(PADDR)];
        end else if (PADDR[7:0] == ieb_pkg::OFS_STATUS) begin
            rdata[10:0] = status_r;
        end else if (PADDR[7:0] == ieb_pkg::OFS_MASK) begin
            rdata[10:0] = mask_r;
        end else begin
            rd_err = 1'h1;
        end
    end

    // apb answer: one wait state, data and error captured with ready
    always_ff @(posedge CLK) begin
        if (SRST) begin
            PREADY    <= 1'h0;
            PRDATA    <= 32'h0000_0000;
            PSLVERR   <= 1'h0;
            rd_snap_r <= 11'h000;
        end else begin
            PREADY <= access & ~PREADY;
            if (access && !PREADY) begin
                PRDATA    <= PWRITE ? 32'h0000_0000 : rdata;
                PSLVERR   <= rd_err;
                rd_snap_r <= rdata[10:0];
            end else if (!access) begin
                PSLVERR <= 1'h0;
            end
        end
    end

    // request to core, gated by the global enable
    always_ff @(posedge CLK) begin
        if (SRST) begin
            CORE_IRQ_REQ <= 1'h0;
        end else begin
            CORE_IRQ_REQ <= bank_r[ieb_pkg::IDX_CTRL0][ieb_pkg::GIE_BIT]
                & |(pack_flags(bank_r[ieb_pkg::IDX_CTRL0],
                               bank_r[ieb_pkg::IDX_CTRL1],
                               bank_r[ieb_pkg::IDX_CTRL2])
                  & pack_enables(bank_r[ieb_pkg::IDX_CTRL0],
                                 bank_r[ieb_pkg::IDX_CTRL1],
                                 bank_r[ieb_pkg::IDX_CTRL2]));
        end
    end

    // status interrupt level, registered from status_nxt in the same cycle as the status register
    always_ff @(posedge CLK) begin
        if (SRST) begin
            IRQ <= 1'h0;
        end else begin
            IRQ <= |(status_nxt & mask_r);
        end
    end

endmodule : ieb_top

`default_nettype wire
